/* design/pmc_power_mode_controller.sv */
`timescale 1ns/1ns
// Contract
// - sleep instruction in active mode enters sleep when mode bits select it
// - in sleep with low_speed_on set, any wake source moves to subactive
// - in subsleep, only the subsleep-capable sources move to subactive
// - no wake to subactive when cpu mask is set or source disabled
// - subactive left only by sleep instruction, rst_in or external reset
// - subactive sleep with direct on, low speed off goes active after wait
// - external reset low forces reset state, cancels subactive
// - standby_timer_sel picks the wait; code 4 gives 131,072 states
// - direct_transfer_on sleep moves active to subactive without halting; subactive to active halts through the wait
// - a finished direct transition raises the direct-transition request
// - direct transition with its enable clear enters sleep or subsleep
// - direct transition with cpu mask set enters a sleep no irq clears
// - software_standby clear: active sleeps; subactive sleeps whatever its value
// - sleep_mode_sel clear picks sleep rather than subsleep
// - low_speed_on set picks among sleep, subsleep, standby and subactive
// - direct_transfer_on clear picks sleep, subsleep or standby
// - active_clk_sel picks the active clock; code 3 is undivided oscillator
// - sub_clk_sel picks the subactive clock; code 0 is subclock over 8
// - edge select bit 0 detects falling, 1 detects rising edges
// - enable register bit 1 enables the matching request
// - request register bit 1 shows a pending request
module pmc_power_mode_controller
  import pmc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // register port
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [7:0]  rdata_out,
  // cpu side
  input  wire logic        sleep_exec_in,
  input  wire logic        cpu_imask_in,
  input  wire logic        timer_a_event_in,
  input  wire logic        other_wake_irq_in,
  input  wire logic        other_subsleep_irq_in,
  // pins
  input  wire logic        external_reset_n_in,
  input  wire logic        ext_wake_line_0_in,
  input  wire logic        ext_wake_line_1_in,
  // mode and clock outputs
  output logic      [5:0]  mode_out,
  output logic             cpu_run_out,
  output logic             reset_hold_out,
  output logic             use_subclock_out,
  output logic      [2:0]  active_clk_sel_out,
  output logic      [1:0]  sub_clk_sel_out,
  output logic             irq_request_out
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0]   standby_control_q;
  logic [7:0]   mode_clock_control_q;
  logic [7:0]   wake_edge_select_q;
  logic [7:0]   wake_irq_enable_q;
  logic [7:0]   wake_irq_flags_q;
  logic [7:0]   wake_irq_flags_d;
  pmc_mode_type mode_q;
  pmc_mode_type mode_d;
  logic [17:0]  wait_q;
  logic [17:0]  wait_d;
  logic         no_irq_wake_q;
  logic         no_irq_wake_d;
  logic         direct_pend_q;
  logic         direct_pend_d;
  logic [2:0]   rst_sync_q;
  logic [2:0]   l0_sync_q;
  logic [2:0]   l1_sync_q;

  wire sel_sc  = addr_in == PMC_ADDR_STANDBY_CONTROL;
  wire sel_mc  = addr_in == PMC_ADDR_MODE_CLOCK_CONTROL;
  wire sel_es  = addr_in == PMC_ADDR_WAKE_EDGE_SELECT;
  wire sel_en  = addr_in == PMC_ADDR_WAKE_IRQ_ENABLE;
  wire sel_fl  = addr_in == PMC_ADDR_WAKE_IRQ_FLAGS;

  wire       software_standby   = standby_control_q[PMC_SOFTWARE_STANDBY_BIT];
  wire [2:0] standby_timer_sel  = standby_control_q[PMC_STS_HI:PMC_STS_LO];
  wire       sleep_mode_sel     = mode_clock_control_q[PMC_SLEEP_MODE_SEL_BIT];
  wire       low_speed_on       = mode_clock_control_q[PMC_LOW_SPEED_ON_BIT];
  wire       direct_transfer_on = mode_clock_control_q[PMC_DIRECT_TRANSFER_ON_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: only stage 1 and 2 are read, stage 0 feeds stage 1

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rst_sync_q <= 3'h7;
      l0_sync_q  <= 3'h0;
      l1_sync_q  <= 3'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[1:0], external_reset_n_in};
      l0_sync_q  <= {l0_sync_q[1:0], ext_wake_line_0_in};
      l1_sync_q  <= {l1_sync_q[1:0], ext_wake_line_1_in};
    end
  end

  // reset held while the synchronised line is low; registers return to reset
  wire ext_reset = ~rst_sync_q[1];
  wire any_reset = rst_in | ext_reset;

  // edge select: 0 falling, 1 rising
  wire l0_edge = wake_edge_select_q[PMC_LINE0_BIT] ?
                 (l0_sync_q[1] & ~l0_sync_q[2]) : (~l0_sync_q[1] & l0_sync_q[2]);
  wire l1_edge = wake_edge_select_q[PMC_LINE1_BIT] ?
                 (l1_sync_q[1] & ~l1_sync_q[2]) : (~l1_sync_q[1] & l1_sync_q[2]);

  ////////////////////////////////////////////////////////////////////////////
  // request flags

  wire direct_blocked = ~wake_irq_enable_q[PMC_DIRECT_BIT] | cpu_imask_in;
  // active to subactive needs no oscillator wait, so it completes at once
  wire direct_to_sub  = (mode_q == PMC_ACTIVE) && sleep_exec_in && direct_transfer_on &&
                        low_speed_on && !direct_blocked;
  wire direct_done    = ((mode_q == PMC_OSC_WAIT) && (wait_q == 18'h00000) && direct_pend_q) |
                        direct_to_sub;
  wire [7:0] hw_set   = {direct_done, timer_a_event_in, 4'h0, l1_edge, l0_edge};
  wire [7:0] pending  = wake_irq_flags_q & wake_irq_enable_q;

  always_comb begin
    wake_irq_flags_d = wake_irq_flags_q;
    if (wr_in && sel_fl) begin
      wake_irq_flags_d = wake_irq_flags_q & wdata_in;
    end
    // a set in the clearing cycle wins
    wake_irq_flags_d = (wake_irq_flags_d | hw_set) & PMC_IRQ_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake qualification

  wire irq_ok     = ~cpu_imask_in & ~no_irq_wake_q;
  wire sleep_wake = irq_ok & ((|pending) | other_wake_irq_in);
  wire sub_wake   = irq_ok & (pending[PMC_TIMER_A_BIT] | pending[PMC_LINE0_BIT] |
                              pending[PMC_LINE1_BIT] | other_subsleep_irq_in);

  always_comb begin
    logic [17:0] wait_states;
    wait_states = PMC_WAIT_STATES_0;
    unique case (standby_timer_sel)
      3'h0: wait_states = PMC_WAIT_STATES_0;
      3'h1: wait_states = PMC_WAIT_STATES_1;
      3'h2: wait_states = PMC_WAIT_STATES_2;
      3'h3: wait_states = PMC_WAIT_STATES_3;
      3'h4: wait_states = PMC_WAIT_STATES_4;
      3'h5: wait_states = PMC_WAIT_STATES_5;
      3'h6: wait_states = PMC_WAIT_STATES_6;
      3'h7: wait_states = PMC_WAIT_STATES_7;
    endcase
    mode_d        = mode_q;
    wait_d        = (wait_q != 18'h00000) ? wait_q - 18'h00001 : wait_q;
    no_irq_wake_d = no_irq_wake_q;
    direct_pend_d = direct_pend_q;
    unique case (mode_q)
      PMC_ACTIVE: begin
        if (sleep_exec_in) begin
          if (direct_transfer_on && low_speed_on && !direct_blocked) begin
            mode_d        = PMC_SUBACTIVE;
          end else if (direct_transfer_on && low_speed_on) begin
            mode_d        = sleep_mode_sel ? PMC_SUBSLEEP : PMC_SLEEP;
            no_irq_wake_d = cpu_imask_in;
          end else if (software_standby && !direct_transfer_on) begin
            mode_d = PMC_STANDBY;
          end else begin
            mode_d = sleep_mode_sel ? PMC_SUBSLEEP : PMC_SLEEP;
          end
        end
      end
      PMC_SLEEP: begin
        if (sleep_wake) begin
          mode_d = low_speed_on ? PMC_SUBACTIVE : PMC_ACTIVE;
        end
      end
      PMC_SUBSLEEP: begin
        if (sub_wake) begin
          mode_d = PMC_SUBACTIVE;
        end
      end
      PMC_SUBACTIVE: begin
        // only a sleep instruction leaves here, besides reset
        if (sleep_exec_in) begin
          if (direct_transfer_on && !low_speed_on && !direct_blocked) begin
            mode_d        = PMC_OSC_WAIT;
            wait_d        = wait_states;
            direct_pend_d = 1'b1;
          end else if (direct_transfer_on && !low_speed_on) begin
            mode_d        = sleep_mode_sel ? PMC_SUBSLEEP : PMC_SLEEP;
            no_irq_wake_d = cpu_imask_in;
          end else begin
            mode_d = sleep_mode_sel ? PMC_SUBSLEEP : PMC_SLEEP;
          end
        end
      end
      PMC_STANDBY: begin
        if (sleep_wake) begin
          mode_d = PMC_OSC_WAIT;
          wait_d = wait_states;
        end
      end
      PMC_OSC_WAIT: begin
        if (wait_q == 18'h00000) begin
          mode_d        = PMC_ACTIVE;
          direct_pend_d = 1'b0;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes: external reset returns everything to reset values

  always_ff @(posedge clk_in) begin
    if (any_reset) begin
      standby_control_q    <= PMC_RST_STANDBY_CONTROL;
      mode_clock_control_q <= PMC_RST_MODE_CLOCK_CONTROL;
      wake_edge_select_q   <= PMC_RST_EDGE;
      wake_irq_enable_q    <= PMC_RST_ENABLE;
      wake_irq_flags_q     <= PMC_RST_FLAGS;
    end else begin
      if (wr_in && sel_sc) begin
        standby_control_q <= wdata_in;
      end
      if (wr_in && sel_mc) begin
        mode_clock_control_q <= wdata_in;
      end
      if (wr_in && sel_es) begin
        wake_edge_select_q <= wdata_in & PMC_EDGE_MASK;
      end
      if (wr_in && sel_en) begin
        wake_irq_enable_q <= wdata_in & PMC_IRQ_MASK;
      end
      wake_irq_flags_q <= wake_irq_flags_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode state

  always_ff @(posedge clk_in) begin
    if (any_reset) begin
      mode_q        <= PMC_ACTIVE;
      wait_q        <= 18'h00000;
      no_irq_wake_q <= 1'b0;
      direct_pend_q <= 1'b0;
    end else begin
      mode_q        <= mode_d;
      wait_q        <= wait_d;
      no_irq_wake_q <= no_irq_wake_d;
      direct_pend_q <= direct_pend_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: unmapped offsets read as zero

  wire [7:0] rd_mux = sel_sc ? standby_control_q :
                      sel_mc ? mode_clock_control_q :
                      sel_es ? wake_edge_select_q :
                      sel_en ? wake_irq_enable_q :
                      sel_fl ? wake_irq_flags_q : 8'h00;

  wire next_runs   = (mode_d == PMC_ACTIVE) || (mode_d == PMC_SUBACTIVE);
  wire next_subclk = (mode_d == PMC_SUBACTIVE) || (mode_d == PMC_SUBSLEEP);

  logic [7:0] rdata_q;
  logic       run_q;
  logic       hold_q;
  logic       subclk_q;
  logic       irq_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_in ? rd_mux : 8'h00;
    end
  end

  // outputs follow the next mode so they agree with mode_out in every cycle outside reset
  always_ff @(posedge clk_in) begin
    hold_q <= any_reset;
    if (any_reset) begin
      run_q    <= 1'b0;
      subclk_q <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      run_q    <= next_runs;
      subclk_q <= next_subclk;
      irq_q    <= |(wake_irq_flags_d & wake_irq_enable_q);
    end
  end

  assign rdata_out          = rdata_q;
  assign mode_out           = mode_q;
  assign cpu_run_out        = run_q;
  assign reset_hold_out     = hold_q;
  assign use_subclock_out   = subclk_q;
  assign irq_request_out    = irq_q;
  assign active_clk_sel_out = mode_clock_control_q[PMC_ACT_CLK_HI:PMC_ACT_CLK_LO];
  assign sub_clk_sel_out    = mode_clock_control_q[PMC_SUB_CLK_HI:PMC_SUB_CLK_LO];

endmodule

/* design/pmc_pkg.sv */
package pmc_pkg;

  // register offsets
  localparam logic [15:0] PMC_ADDR_STANDBY_CONTROL    = 16'hfff0;
  localparam logic [15:0] PMC_ADDR_MODE_CLOCK_CONTROL = 16'hfff1;
  localparam logic [15:0] PMC_ADDR_WAKE_EDGE_SELECT   = 16'hfff2;
  localparam logic [15:0] PMC_ADDR_WAKE_IRQ_ENABLE    = 16'hfff4;
  localparam logic [15:0] PMC_ADDR_WAKE_IRQ_FLAGS     = 16'hfff6;

  // standby_control fields
  localparam int PMC_SOFTWARE_STANDBY_BIT = 7;
  localparam int PMC_STS_HI               = 6;
  localparam int PMC_STS_LO               = 4;
  // mode_clock_control fields
  localparam int PMC_SLEEP_MODE_SEL_BIT     = 7;
  localparam int PMC_LOW_SPEED_ON_BIT       = 6;
  localparam int PMC_DIRECT_TRANSFER_ON_BIT = 5;
  localparam int PMC_ACT_CLK_HI             = 4;
  localparam int PMC_ACT_CLK_LO             = 2;
  localparam int PMC_SUB_CLK_HI             = 1;
  localparam int PMC_SUB_CLK_LO             = 0;
  // wake_edge_select / enable / flags fields
  localparam int PMC_LINE0_BIT = 0;
  localparam int PMC_LINE1_BIT = 1;
  localparam int PMC_TIMER_A_BIT = 6;
  localparam int PMC_DIRECT_BIT  = 7;

  // reset values and write masks
  localparam logic [7:0] PMC_RST_STANDBY_CONTROL    = 8'h00;
  localparam logic [7:0] PMC_RST_MODE_CLOCK_CONTROL = 8'h00;
  localparam logic [7:0] PMC_RST_EDGE               = 8'h00;
  localparam logic [7:0] PMC_RST_ENABLE             = 8'h00;
  localparam logic [7:0] PMC_RST_FLAGS              = 8'h00;
  localparam logic [7:0] PMC_EDGE_MASK              = 8'h03;
  localparam logic [7:0] PMC_IRQ_MASK               = 8'hc3;

  // clocks: main oscillator 100 MHz here, selector codes
  localparam logic [2:0] PMC_ACT_CLK_OSC_UNDIV = 3'h3;
  localparam logic [1:0] PMC_SUB_CLK_DIV8      = 2'h0;

  // stabilisation waits in states, indexed by standby_timer_sel
  localparam logic [17:0] PMC_WAIT_STATES_4 = 18'h20000;  // 131,072 states
  localparam logic [17:0] PMC_WAIT_STATES_0 = 18'h02000;
  localparam logic [17:0] PMC_WAIT_STATES_1 = 18'h04000;
  localparam logic [17:0] PMC_WAIT_STATES_2 = 18'h08000;
  localparam logic [17:0] PMC_WAIT_STATES_3 = 18'h10000;
  localparam logic [17:0] PMC_WAIT_STATES_5 = 18'h00002;
  localparam logic [17:0] PMC_WAIT_STATES_6 = 18'h00010;
  localparam logic [17:0] PMC_WAIT_STATES_7 = 18'h00400;

  typedef enum logic [5:0] {
    PMC_ACTIVE    = 6'h01,
    PMC_SLEEP     = 6'h02,
    PMC_SUBSLEEP  = 6'h04,
    PMC_SUBACTIVE = 6'h08,
    PMC_STANDBY   = 6'h10,
    PMC_OSC_WAIT  = 6'h20
  } pmc_mode_type;

endpackage

/* dv/pmc_props.sv */
`timescale 1ns/1ns
module pmc_props
  import pmc_pkg::*;
(
  // clock and reset
  input wire logic        clk_in,
  input wire logic        rst_in,
  // inputs watched
  input wire logic [15:0] addr_in,
  input wire logic [7:0]  wdata_in,
  input wire logic        wr_in,
  input wire logic        sleep_exec_in,
  input wire logic        cpu_imask_in,
  input wire logic        external_reset_n_in,
  // outputs watched
  input wire logic [5:0]  mode_out,
  input wire logic        cpu_run_out,
  input wire logic        reset_hold_out,
  input wire logic        use_subclock_out,
  input wire logic [2:0]  active_clk_sel_out,
  input wire logic [1:0]  sub_clk_sel_out,
  input wire logic        irq_request_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire logic mcc_wr = wr_in && (addr_in == PMC_ADDR_MODE_CLOCK_CONTROL);
  ////////////////////////////////////////////////////////////////////////////////
  AST_SLEEP_LEAVES: assert property (mode_out == PMC_ACTIVE && sleep_exec_in
    |-> ##[1:4] mode_out != PMC_ACTIVE) else $error("sleep did not leave active");
  AST_SLEEP_HALT: assert property (mode_out == PMC_SLEEP |-> !cpu_run_out)
    else $error("cpu runs in sleep");
  AST_MASK_NO_WAKE: assert property (mode_out == PMC_SLEEP && cpu_imask_in
    |=> mode_out != PMC_SUBACTIVE) else $error("masked wake");
  // a sleep seen last cycle may still be in flight, so it is excused too
  // the reset pin passes two synchroniser stages before the register stage
  AST_SUB_STAYS: assert property (mode_out == PMC_SUBACTIVE && !sleep_exec_in
    && !$past(sleep_exec_in) && external_reset_n_in |=> mode_out == PMC_SUBACTIVE)
    else $error("subactive left without cause");
  AST_EXT_RESET: assert property (!external_reset_n_in
    |-> ##3 (reset_hold_out && mode_out != PMC_SUBACTIVE)) else $error("reset not taken");
  AST_SUB_RUNS: assert property (mode_out == PMC_SUBACTIVE
    |-> use_subclock_out && cpu_run_out) else $error("subactive clocking wrong");
  AST_DT_REQ: assert property ($past(mode_out) == PMC_OSC_WAIT
    && mode_out == PMC_ACTIVE |-> ##[0:2] irq_request_out) else $error("no direct irq");
  AST_ACT_CLK: assert property (mcc_wr
    |=> active_clk_sel_out == $past(wdata_in[4:2])) else $error("active clock select");
  AST_SUB_CLK: assert property (mcc_wr
    |=> sub_clk_sel_out == $past(wdata_in[1:0])) else $error("sub clock select");
  cover property (mode_out == PMC_SUBACTIVE);
  cover property ($past(mode_out) == PMC_OSC_WAIT && mode_out == PMC_ACTIVE);
  cover property (!external_reset_n_in && reset_hold_out);
endmodule
bind pmc_power_mode_controller pmc_props u_pmc_props (.clk_in(clk_in), .rst_in(rst_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .sleep_exec_in(sleep_exec_in),
  .cpu_imask_in(cpu_imask_in), .external_reset_n_in(external_reset_n_in),
  .mode_out(mode_out), .cpu_run_out(cpu_run_out), .reset_hold_out(reset_hold_out),
  .use_subclock_out(use_subclock_out), .active_clk_sel_out(active_clk_sel_out),
  .sub_clk_sel_out(sub_clk_sel_out), .irq_request_out(irq_request_out));

/* dv/pmc_cpu_model.sv */
`timescale 1ns/1ns
module pmc_cpu_model #(
  parameter int RESET_HOLD = 8
) (
  // clock and bench requests
  input  wire logic clk_in,
  input  wire logic sleep_req_in,
  input  wire logic reset_req_in,
  // toward the controller
  output logic      sleep_exec_out = 1'b0,
  output logic      external_reset_n_out
);
  logic [7:0] hold_q = 8'h00;
  // one sleep instruction per requested cycle
  always @(posedge clk_in) begin
    sleep_exec_out <= sleep_req_in;
    if (reset_req_in) begin
      hold_q <= 8'(RESET_HOLD);
    end else if (hold_q != 8'h00) begin
      hold_q <= hold_q - 8'h01;
    end
  end
  // line kept low for RESET_HOLD cycles after a reset request
  assign external_reset_n_out = (hold_q == 8'h00);
endmodule

/* dv/pmc_power_mode_controller_tb.sv */
`timescale 1ns/1ns
module pmc_power_mode_controller_tb;
  import pmc_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [15:0] addr_in = 16'h0000;
  logic [7:0]  wdata_in = 8'h00;
  logic        wr_in = 1'b0, rd_in = 1'b0, sleep_req = 1'b0, reset_req = 1'b0;
  logic        cpu_imask_in = 1'b0, timer_a = 1'b0, line0 = 1'b0, line1 = 1'b1;
  logic        sleep_exec, ext_n, run, hold, subclk, irq;
  logic [7:0]  rdata_out;
  logic [5:0]  mode_out;
  logic [2:0]  act_sel;
  logic [1:0]  sub_sel;
  int          bad_count = 0, num_checks = 0, cycles = 0;
  logic [15:0] regs [6] = '{16'hfff0, 16'hfff1, 16'hfff2, 16'hfff3, 16'hfff4, 16'hfff6};
  ////////////////////////////////////////////////////////////////////////////////
  pmc_power_mode_controller u_pmc_power_mode_controller (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .sleep_exec_in(sleep_exec), .cpu_imask_in(cpu_imask_in),
    .timer_a_event_in(timer_a), .other_wake_irq_in(1'b0), .other_subsleep_irq_in(1'b0),
    .external_reset_n_in(ext_n), .ext_wake_line_0_in(line0), .ext_wake_line_1_in(line1),
    .mode_out(mode_out), .cpu_run_out(run), .reset_hold_out(hold),
    .use_subclock_out(subclk), .active_clk_sel_out(act_sel), .sub_clk_sel_out(sub_sel),
    .irq_request_out(irq));
  pmc_cpu_model u_pmc_cpu_model (.clk_in(clk_in), .sleep_req_in(sleep_req),
    .reset_req_in(reset_req), .sleep_exec_out(sleep_exec), .external_reset_n_out(ext_n));
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #5 clk_in = ~clk_in;
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // a hang costs a mismatch; normal flow needs well under a thousand cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(what, rdata_out, exp);
  endtask
  task automatic wait_mode(input pmc_mode_type m, input int n);
    for (int i = 0; i < n && mode_out !== m; i++) @(posedge clk_in) #1;
    chk("mode", {2'b00, mode_out}, {2'b00, m});
  endtask
  task automatic sleep();
    @(posedge clk_in);
    sleep_req <= 1'b1;
    @(posedge clk_in);
    sleep_req <= 1'b0;
  endtask
  task automatic pins(input logic l0, input logic l1, input logic ta, input logic im);
    @(posedge clk_in);
    line0 <= l0;
    line1 <= l1;
    timer_a <= ta;
    cpu_imask_in <= im;
    repeat (3) @(posedge clk_in);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    foreach (regs[i]) rd_chk(regs[i], 8'h00, "reset value");
    wr_reg(PMC_ADDR_WAKE_EDGE_SELECT, 8'hff);
    rd_chk(PMC_ADDR_WAKE_EDGE_SELECT, 8'h03, "edge select");
    wr_reg(PMC_ADDR_WAKE_IRQ_ENABLE, 8'hff);
    rd_chk(PMC_ADDR_WAKE_IRQ_ENABLE, 8'hc3, "irq enable");
    wr_reg(PMC_ADDR_WAKE_EDGE_SELECT, 8'h01);
    wr_reg(PMC_ADDR_WAKE_IRQ_ENABLE, 8'h80);
    // wait code 5 keeps the stabilisation wait short
    wr_reg(PMC_ADDR_STANDBY_CONTROL, 8'h50);
    wr_reg(PMC_ADDR_MODE_CLOCK_CONTROL, 8'h4c);
    sleep();
    wait_mode(PMC_SLEEP, 10);
    pins(1'b1, 1'b0, 1'b1, 1'b0);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    chk("disabled", {2'b00, mode_out}, {2'b00, PMC_SLEEP});
    rd_chk(PMC_ADDR_WAKE_IRQ_FLAGS, 8'h43, "flags");
    wr_reg(PMC_ADDR_WAKE_IRQ_FLAGS, 8'h00);
    rd_chk(PMC_ADDR_WAKE_IRQ_FLAGS, 8'h00, "flags");
    wr_reg(PMC_ADDR_WAKE_IRQ_ENABLE, 8'h81);
    pins(1'b1, 1'b0, 1'b0, 1'b1);
    chk("masked", {2'b00, mode_out}, {2'b00, PMC_SLEEP});
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    wait_mode(PMC_SUBACTIVE, 20);
    repeat (20) @(posedge clk_in);
    chk("subclock", {7'h00, subclk}, 8'h01);
    wr_reg(PMC_ADDR_WAKE_IRQ_FLAGS, 8'h00);
    wr_reg(PMC_ADDR_MODE_CLOCK_CONTROL, 8'h2c);
    sleep();
    wait_mode(PMC_ACTIVE, 60);
    rd_chk(PMC_ADDR_WAKE_IRQ_FLAGS, 8'h80, "direct flag");
    chk("act clk", {5'h00, act_sel}, {5'h00, PMC_ACT_CLK_OSC_UNDIV});
    wr_reg(PMC_ADDR_MODE_CLOCK_CONTROL, 8'h6c);
    sleep();
    wait_mode(PMC_SUBACTIVE, 60);
    chk("sub clk", {6'h00, sub_sel}, {6'h00, PMC_SUB_CLK_DIV8});
    @(posedge clk_in);
    reset_req <= 1'b1;
    @(posedge clk_in);
    reset_req <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1 chk("reset hold", {7'h00, hold}, 8'h01);
    wait_mode(PMC_ACTIVE, 60);
    final_report();
  end
endmodule
